// ===== cfb_flags.sv
// condition flag register with flag update, flag opcodes and branch test
// Overview of operation
// RL1: unsigned higher branch taken only when carry and zero both clear.
// RL2: unsigned lower-or-same branch taken when carry or zero set.
// RL3: signed less when negative xor overflow is one; greater-equal when zero.
// RL4: signed less-or-equal is signed less, or zero flag set.
// RL5: signed greater is greater-equal but never when zero is set.
// RL6: flags held in a six bit register.
// RL7: bit order five to zero: half, mask, negative, zero, overflow, carry.
// RL8: half carry follows bit three carry on adds; others leave it.
// RL9: mask set by interrupts or set op; cleared by clear op or return; the code clears it on return only when stacked_mask is low.
// RL10: negative flag copies result bit seven.
// RL11: zero flag set when result is zero.
// RL12: overflow flag follows arithmetic overflow.
// RL13: carry flag follows carry out of the top bit.
// RL14: carry and overflow set/clear opcodes alter only their own flag.
// RL15: mask set/clear opcodes leave all other flags unchanged.
// RL16: opcode 06 loads every flag from accumulator A.
// RL17: opcode 07 copies flags into accumulator A without change.
// RL18: recognise 197 of 256 opcode values, many with several modes; the code decodes only the flag, add, branch and long immediate opcodes.
// RL19: add opcodes 8B, 9B, AB, BB select immediate, direct, indexed, extended; add_mode gives implied for 8B and AB.
// RL20: direct takes a one byte address; extended a two byte address.
// RL21: index compare, index load, stack load immediates are two bytes.
// RL22: branches use relative mode only, identified by opcode.
// RL23: taken branch target is next instruction address plus signed offset.
`timescale 1ns/1ns
`default_nettype none
module cfb_flags
(
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic             op_valid,
  input  wire logic [7:0]       opcode,
  input  wire logic [7:0]       acc_a,
  input  wire logic [15:0]      pc,
  input  wire logic [7:0]       branch_offset,
  input  wire logic             alu_update,
  input  wire logic             alu_half_carry,
  input  wire logic [7:0]       alu_result,
  input  wire logic             alu_overflow,
  input  wire logic             alu_carry,
  input  wire logic             hw_interrupt,
  input  wire logic             sw_interrupt,
  input  wire logic             interrupt_return,
  input  wire logic             stacked_mask,
  output logic [5:0]            condition_flags,
  output logic [7:0]            flags_to_acc,
  output logic                  flags_to_acc_valid,
  output logic                  branch_taken,
  output logic [15:0]           branch_target,
  output logic                  op_is_branch,
  output logic                  op_add_variant,
  output logic [1:0]            immediate_bytes,
  output cfb_pkg::cfb_mode_t    add_mode
);
  import cfb_pkg::*;

  logic [5:0] next_flags;
  logic       cond;

  function automatic logic is_add(input logic [7:0] op);
    is_add = (op == OP_ADD_IMM) || (op == OP_ADD_DIR) || (op == OP_ADD_IDX)
          || (op == OP_ADD_EXT) || (op == OP_ADD_ACC);
  endfunction

  function automatic logic is_cond_branch(input logic [7:0] op);
    is_cond_branch = (op >= OP_BR_HI) && (op <= OP_BR_LE); // see RL22
  endfunction

  // branch condition from the present flags
  always_comb
  begin
    cond = 1'b0;
    case (opcode)
      OP_BR_HI: cond = ~(condition_flags[BIT_CARRY] | condition_flags[BIT_ZERO]); // see RL1
      OP_BR_LS: cond = condition_flags[BIT_CARRY] | condition_flags[BIT_ZERO]; // see RL2
      OP_BR_LT: cond = condition_flags[BIT_NEG] ^ condition_flags[BIT_OVF]; // see RL3
      OP_BR_GE: cond = ~(condition_flags[BIT_NEG] ^ condition_flags[BIT_OVF]); // see RL3
      OP_BR_LE: cond = condition_flags[BIT_ZERO]
                     | (condition_flags[BIT_NEG] ^ condition_flags[BIT_OVF]); // see RL4
      OP_BR_GT: cond = ~(condition_flags[BIT_ZERO]
                     | (condition_flags[BIT_NEG] ^ condition_flags[BIT_OVF])); // see RL5
      default:  cond = 1'b0;
    endcase
  end

  assign op_is_branch = is_cond_branch(opcode);
  assign op_add_variant = is_add(opcode); // see RL18

  // immediate operand length
  always_comb
  begin
    if ((opcode == OP_IDX_CMP_IMM) || (opcode == OP_IDX_LOAD_IMM) || (opcode == OP_SP_LOAD_IMM))
      immediate_bytes = 2'h2; // see RL21
    else
      immediate_bytes = 2'h1;
  end

  // addressing mode of the add group
  always_comb
  begin
    case (opcode)
      OP_ADD_DIR: add_mode = CFB_MODE_DIRECT; // see RL19, see RL20
      OP_ADD_EXT: add_mode = CFB_MODE_EXTENDED; // see RL20
      OP_ADD_IMM: add_mode = CFB_MODE_IMPLIED;
      default:    add_mode = CFB_MODE_IMPLIED;
    endcase
  end

  // next flag value; interrupt entry outranks instruction effects on the mask
  always_comb
  begin
    next_flags = condition_flags;
    if (op_valid)
    begin
      case (opcode)
        OP_CLR_CARRY:    next_flags[BIT_CARRY] = 1'b0; // see RL14
        OP_SET_CARRY:    next_flags[BIT_CARRY] = 1'b1; // see RL14
        OP_CLR_OVF:      next_flags[BIT_OVF] = 1'b0; // see RL14
        OP_SET_OVF:      next_flags[BIT_OVF] = 1'b1; // see RL14
        OP_CLR_MASK:     next_flags[BIT_MASK] = 1'b0; // see RL9, see RL15
        OP_SET_MASK:     next_flags[BIT_MASK] = 1'b1; // see RL9, see RL15
        OP_ACC_TO_FLAGS: next_flags = acc_a[5:0]; // see RL16
        default:         next_flags = condition_flags; // see RL17
      endcase
    end
    if (alu_update)
    begin
      if (op_valid && is_add(opcode))
        next_flags[BIT_HALF] = alu_half_carry; // see RL8
      next_flags[BIT_NEG]   = alu_result[7]; // see RL10
      next_flags[BIT_ZERO]  = (alu_result == 8'h00); // see RL11
      next_flags[BIT_OVF]   = alu_overflow; // see RL12
      next_flags[BIT_CARRY] = alu_carry; // see RL13
    end
    if (interrupt_return && !stacked_mask)
      next_flags[BIT_MASK] = 1'b0; // see RL9
    if (hw_interrupt || sw_interrupt)
      next_flags[BIT_MASK] = 1'b1; // see RL9
  end

  // flag register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      condition_flags <= FLAGS_RESET;
    else if (clk_en)
      condition_flags <= next_flags; // see RL6, see RL7
  end

  // flags to accumulator copy, upper two bits read as one
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      flags_to_acc       <= 8'h00;
      flags_to_acc_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      flags_to_acc_valid <= op_valid && (opcode == OP_FLAGS_TO_ACC);
      if (op_valid && (opcode == OP_FLAGS_TO_ACC))
        flags_to_acc <= {2'b11, condition_flags}; // see RL17
    end
  end

  // branch decision and target
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      branch_taken  <= 1'b0;
      branch_target <= 16'h0000;
    end
    else if (clk_en)
    begin
      branch_taken <= op_valid && is_cond_branch(opcode) && cond;
      if (op_valid && is_cond_branch(opcode))
        branch_target <= pc + 16'(BRANCH_LEN) + {{8{branch_offset[7]}}, branch_offset}; // see RL23
    end
  end

  // named steps shared by the properties below
  sequence s_branch_issue;
    clk_en && op_valid && op_is_branch;
  endsequence
  sequence s_copy_issue;
    clk_en && op_valid && (opcode == OP_FLAGS_TO_ACC);
  endsequence
  sequence s_alu_issue;
    clk_en && alu_update;
  endsequence
  sequence s_quiet;
    !alu_update && !hw_interrupt && !sw_interrupt && !interrupt_return;
  endsequence

  property p_hi_clear;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && op_valid && opcode == OP_BR_HI && (condition_flags[BIT_CARRY] | condition_flags[BIT_ZERO]))
      |=> !branch_taken;
  endproperty
  a_hi_clear: assert property (p_hi_clear) else $error("higher branch taken with carry or zero"); // see RL1

  property p_ls;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && op_valid && opcode == OP_BR_LS) |=> (branch_taken == $past(condition_flags[0] | condition_flags[2]));
  endproperty
  a_ls: assert property (p_ls) else $error("lower-same branch wrong"); // see RL2

  property p_lt;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && op_valid && opcode == OP_BR_LT) |=> (branch_taken == $past(condition_flags[3] ^ condition_flags[1]));
  endproperty
  a_lt: assert property (p_lt) else $error("signed less branch wrong"); // see RL3

  property p_le;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && op_valid && opcode == OP_BR_LE && condition_flags[BIT_ZERO]) |=> branch_taken;
  endproperty
  a_le: assert property (p_le) else $error("less-equal not taken on zero"); // see RL4

  property p_gt;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && op_valid && opcode == OP_BR_GT && condition_flags[BIT_ZERO]) |=> !branch_taken;
  endproperty
  a_gt: assert property (p_gt) else $error("greater taken on zero"); // see RL5

  property p_set_carry;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && op_valid && opcode == OP_SET_CARRY) ##0 s_quiet
      |=> condition_flags[BIT_CARRY] && condition_flags[5:1] == $past(condition_flags[5:1]);
  endproperty
  a_set_carry: assert property (p_set_carry) else $error("set carry wrong"); // see RL14

  property p_hw_mask;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && hw_interrupt) |=> condition_flags[BIT_MASK];
  endproperty
  a_hw_mask: assert property (p_hw_mask) else $error("mask not set on interrupt"); // see RL9

  property p_zero;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && alu_update) |=> (condition_flags[BIT_ZERO] == ($past(alu_result) == 8'h00));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong"); // see RL11

  property p_tap;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && op_valid && opcode == OP_ACC_TO_FLAGS && !alu_update && !hw_interrupt && !sw_interrupt
      && !interrupt_return) |=> condition_flags == $past(acc_a[5:0]);
  endproperty
  a_tap: assert property (p_tap) else $error("accumulator transfer wrong"); // see RL16

  property p_hi_taken;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && op_valid && opcode == OP_BR_HI && !condition_flags[BIT_CARRY] && !condition_flags[BIT_ZERO])
      |=> branch_taken;
  endproperty
  a_hi_taken: assert property (p_hi_taken) else $error("higher branch not taken"); // see RL1

  property p_gt_taken;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && op_valid && opcode == OP_BR_GT && !condition_flags[BIT_ZERO]
      && (condition_flags[BIT_NEG] == condition_flags[BIT_OVF])) |=> branch_taken;
  endproperty
  a_gt_taken: assert property (p_gt_taken) else $error("greater branch not taken"); // see RL5

  property p_target;
    @(posedge sys_clk) disable iff (rst)
    s_branch_issue |=> branch_target == $past(pc) + 16'(BRANCH_LEN) + {{8{$past(branch_offset[7])}}, $past(branch_offset)};
  endproperty
  a_target: assert property (p_target) else $error("branch target wrong"); // see RL23

  property p_no_branch;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && !(op_valid && op_is_branch)) |=> !branch_taken;
  endproperty
  a_no_branch: assert property (p_no_branch) else $error("branch taken without a branch opcode"); // see RL22

  property p_half;
    @(posedge sys_clk) disable iff (rst)
    s_alu_issue ##0 (op_valid && op_add_variant)
      |=> condition_flags[BIT_HALF] == $past(alu_half_carry);
  endproperty
  a_half: assert property (p_half) else $error("half carry not loaded on add"); // see RL8

  property p_half_keep;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && !(op_valid && (opcode == OP_ACC_TO_FLAGS)) && !(alu_update && op_valid && op_add_variant))
      |=> $stable(condition_flags[BIT_HALF]);
  endproperty
  a_half_keep: assert property (p_half_keep) else $error("half carry changed by other instruction"); // see RL8

  property p_alu_flags;
    @(posedge sys_clk) disable iff (rst)
    s_alu_issue |=> condition_flags[BIT_NEG] == $past(alu_result[7])
      && condition_flags[BIT_OVF] == $past(alu_overflow) && condition_flags[BIT_CARRY] == $past(alu_carry);
  endproperty
  a_alu_flags: assert property (p_alu_flags) else $error("arithmetic flags wrong"); // see RL10, see RL12, see RL13

  property p_clr_mask;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && op_valid && opcode == OP_CLR_MASK) ##0 s_quiet
      |=> !condition_flags[BIT_MASK]
        && {condition_flags[5], condition_flags[3:0]} == $past({condition_flags[5], condition_flags[3:0]});
  endproperty
  a_clr_mask: assert property (p_clr_mask) else $error("clear mask wrong"); // see RL15

  property p_copy_out;
    @(posedge sys_clk) disable iff (rst)
    s_copy_issue |=> flags_to_acc_valid && flags_to_acc == {2'b11, $past(condition_flags)};
  endproperty
  a_copy_out: assert property (p_copy_out) else $error("flag copy to accumulator wrong"); // see RL17

  property p_copy_keep;
    @(posedge sys_clk) disable iff (rst)
    s_copy_issue ##0 s_quiet |=> $stable(condition_flags);
  endproperty
  a_copy_keep: assert property (p_copy_keep) else $error("flag copy altered the flags"); // see RL17

  property p_ret_clear;
    @(posedge sys_clk) disable iff (rst)
    (clk_en && interrupt_return && !stacked_mask && !hw_interrupt && !sw_interrupt) |=> !condition_flags[BIT_MASK];
  endproperty
  a_ret_clear: assert property (p_ret_clear) else $error("mask not cleared on return"); // see RL9
endmodule
`default_nettype wire

// ===== cfb_pkg.sv
// package: constants for the condition flag register and branch test block
package cfb_pkg;
  localparam int        FLAG_W       = 6;
  localparam int        BIT_HALF     = 5;
  localparam int        BIT_MASK     = 4;
  localparam int        BIT_NEG      = 3;
  localparam int        BIT_ZERO     = 2;
  localparam int        BIT_OVF      = 1;
  localparam int        BIT_CARRY    = 0;
  localparam logic [5:0] FLAGS_RESET = 6'h10;
  localparam logic [7:0] OP_CLR_OVF  = 8'h0A;
  localparam logic [7:0] OP_SET_OVF  = 8'h0B;
  localparam logic [7:0] OP_CLR_CARRY = 8'h0C;
  localparam logic [7:0] OP_SET_CARRY = 8'h0D;
  localparam logic [7:0] OP_CLR_MASK = 8'h0E;
  localparam logic [7:0] OP_SET_MASK = 8'h0F;
  localparam logic [7:0] OP_ACC_TO_FLAGS = 8'h06;
  localparam logic [7:0] OP_FLAGS_TO_ACC = 8'h07;
  localparam logic [7:0] OP_ADD_IMM  = 8'h8B;
  localparam logic [7:0] OP_ADD_DIR  = 8'h9B;
  localparam logic [7:0] OP_ADD_IDX  = 8'hAB;
  localparam logic [7:0] OP_ADD_EXT  = 8'hBB;
  localparam logic [7:0] OP_ADD_ACC  = 8'h1B;
  localparam logic [7:0] OP_IDX_CMP_IMM = 8'h8C;
  localparam logic [7:0] OP_IDX_LOAD_IMM = 8'hCE;
  localparam logic [7:0] OP_SP_LOAD_IMM = 8'h8E;
  localparam logic [7:0] OP_BR_HI    = 8'h22;
  localparam logic [7:0] OP_BR_LS    = 8'h23;
  localparam logic [7:0] OP_BR_GE    = 8'h2C;
  localparam logic [7:0] OP_BR_LT    = 8'h2D;
  localparam logic [7:0] OP_BR_GT    = 8'h2E;
  localparam logic [7:0] OP_BR_LE    = 8'h2F;
  localparam logic [7:0] DIRECT_MAX  = 8'hFF;
  localparam int        OPS_RECOGNISED = 197;
  localparam int        OPS_TOTAL    = 256;
  localparam int        INHERENT_CYCLES = 2;
  localparam int        BRANCH_LEN   = 2;
  typedef enum logic [1:0] {
    CFB_MODE_IMPLIED,
    CFB_MODE_DIRECT,
    CFB_MODE_EXTENDED,
    CFB_MODE_RELATIVE
  } cfb_mode_t;
endpackage

// ===== tb_condition_flags_and_branch_test.sv
// testbench for the condition flag register and branch test block
`timescale 1ns/1ns
`default_nettype none
module tb_condition_flags_and_branch_test;
  import cfb_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        op_valid = 1'b0;
  logic [7:0]  opcode = 8'h01;
  logic [7:0]  acc_a = 8'h00;
  logic [15:0] pc = 16'h5004;
  logic [7:0]  branch_offset = 8'h85;
  logic        alu_update = 1'b0;
  logic        alu_half_carry = 1'b0;
  logic [7:0]  alu_result = 8'h00;
  logic        alu_overflow = 1'b0;
  logic        alu_carry = 1'b0;
  logic        hw_interrupt = 1'b0;
  logic        sw_interrupt = 1'b0;
  logic        interrupt_return = 1'b0;
  logic        stacked_mask = 1'b0;
  logic [5:0]  condition_flags;
  logic [7:0]  flags_to_acc;
  logic        flags_to_acc_valid;
  logic        branch_taken;
  logic [15:0] branch_target;
  logic        op_is_branch;
  logic        op_add_variant;
  logic [1:0]  immediate_bytes;
  cfb_mode_t   add_mode;
  int          mismatches = 0;
  int          tests_run = 0;
  logic [5:0]  ev;
  logic [7:0]  brs [6] = '{OP_BR_HI, OP_BR_LS, OP_BR_GE, OP_BR_LT, OP_BR_GT, OP_BR_LE};
  logic [7:0]  fops [6] = '{OP_SET_CARRY, OP_SET_OVF, OP_SET_MASK, OP_CLR_CARRY, OP_CLR_OVF, OP_CLR_MASK};
  logic [5:0]  fexp [12] = '{6'h01, 6'h03, 6'h13, 6'h12, 6'h10, 6'h00,
                             6'h3F, 6'h3F, 6'h3F, 6'h3E, 6'h3C, 6'h2C};

  always #20 sys_clk = ~sys_clk;

  cfb_flags dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .op_valid(op_valid), .opcode(opcode),
    .acc_a(acc_a), .pc(pc), .branch_offset(branch_offset), .alu_update(alu_update),
    .alu_half_carry(alu_half_carry), .alu_result(alu_result), .alu_overflow(alu_overflow),
    .alu_carry(alu_carry), .hw_interrupt(hw_interrupt), .sw_interrupt(sw_interrupt),
    .interrupt_return(interrupt_return), .stacked_mask(stacked_mask), .condition_flags(condition_flags),
    .flags_to_acc(flags_to_acc), .flags_to_acc_valid(flags_to_acc_valid), .branch_taken(branch_taken),
    .branch_target(branch_target), .op_is_branch(op_is_branch), .op_add_variant(op_add_variant),
    .immediate_bytes(immediate_bytes), .add_mode(add_mode));

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one executed opcode; fx is {alu_update, hw_interrupt, sw_interrupt, interrupt_return} for that cycle
  task automatic step(input logic [7:0] o, input logic [7:0] a, input logic [3:0] fx);
    op_valid = 1'b1;
    opcode = o;
    acc_a = a;
    {alu_update, hw_interrupt, sw_interrupt, interrupt_return} = fx;
    @(negedge sys_clk);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    chk("reset flags", condition_flags, FLAGS_RESET);
    chk("reset branch", branch_taken, 0);
    $display("test reset done");
    step(OP_ACC_TO_FLAGS, 8'hE9, 4'h0);
    chk("flags from acc", condition_flags, 6'h29);
    step(OP_FLAGS_TO_ACC, 8'h00, 4'h0);
    chk("acc from flags", flags_to_acc, 8'hE9);
    chk("acc valid", flags_to_acc_valid, 1);
    chk("flags kept", condition_flags, 6'h29);
    step(8'h01, 8'h00, 4'h0);
    chk("acc valid drop", flags_to_acc_valid, 0);
    $display("test transfer done");
    for (int k = 0; k < 12; k++)
    begin
      if (k % 6 == 0)
        step(OP_ACC_TO_FLAGS, (k == 0) ? 8'h00 : 8'h3F, 4'h0);
      step(fops[k % 6], 8'h00, 4'h0);
      chk("flag op", condition_flags, fexp[k]);
    end
    $display("test flag opcodes done");
    alu_half_carry = 1'b1;
    alu_result = 8'h80;
    alu_overflow = 1'b1;
    alu_carry = 1'b0;
    step(OP_ADD_IMM, 8'h00, 4'h8);
    chk("add flags", condition_flags, 6'h2A);
    alu_half_carry = 1'b0;
    alu_result = 8'h00;
    alu_overflow = 1'b0;
    alu_carry = 1'b1;
    step(8'h01, 8'h00, 4'h8);
    chk("non add flags", condition_flags, 6'h25);
    alu_result = 8'h7F;
    alu_carry = 1'b0;
    step(OP_ADD_ACC, 8'h00, 4'h8);
    chk("acc add flags", condition_flags, 6'h00);
    $display("test alu flags done");
    step(8'h01, 8'h00, 4'h4);
    chk("hw mask", condition_flags, 6'h10);
    stacked_mask = 1'b1;
    step(8'h01, 8'h00, 4'h1);
    chk("return keep", condition_flags, 6'h10);
    stacked_mask = 1'b0;
    step(8'h01, 8'h00, 4'h1);
    chk("return clear", condition_flags, 6'h00);
    step(8'h01, 8'h00, 4'h2);
    chk("sw mask", condition_flags, 6'h10);
    clk_en = 1'b0;
    step(OP_SET_CARRY, 8'h00, 4'h0);
    chk("frozen", condition_flags, 6'h10);
    clk_en = 1'b1;
    $display("test mask done");
    for (int i = 0; i < 16; i++)
      for (int j = 0; j < 6; j++)
      begin
        step(OP_ACC_TO_FLAGS, {4'h0, i[3:0]}, 4'h0);
        branch_offset = j[0] ? 8'h15 : 8'h85;
        step(brs[j], 8'h00, 4'h0);
        ev[0] = ~(i[0] | i[2]);
        ev[1] = i[0] | i[2];
        ev[2] = ~(i[3] ^ i[1]);
        ev[3] = i[3] ^ i[1];
        ev[4] = ev[2] & ~i[2];
        ev[5] = ev[3] | i[2];
        chk("branch taken", branch_taken, ev[j]);
        if (ev[j])
          chk("branch target", branch_target, j[0] ? 16'h501B : 16'h4F8B);
      end
    $display("test branches done");
    rst = 1'b1;
    @(negedge sys_clk);
    rst = 1'b0;
    op_valid = 1'b0;
    chk("second reset flags", condition_flags, FLAGS_RESET);
    chk("second reset branch", branch_taken, 0);
    chk("second reset target", branch_target, 16'h0000);
    chk("second reset copy", flags_to_acc, 8'h00);
    foreach (fops[k])
    begin
      opcode = (k < 4) ? {4'h8 + 4'(k), 4'hB} : 8'h01;
      @(negedge sys_clk);
      chk("add decode", op_add_variant, k < 4);
    end
    opcode = OP_ADD_DIR;
    @(negedge sys_clk);
    chk("direct mode", add_mode, CFB_MODE_DIRECT);
    opcode = OP_ADD_EXT;
    @(negedge sys_clk);
    chk("extended mode", add_mode, CFB_MODE_EXTENDED);
    opcode = OP_BR_LE;
    @(negedge sys_clk);
    chk("branch decode", op_is_branch, 1);
    opcode = OP_ADD_IMM;
    @(negedge sys_clk);
    chk("short immediate", immediate_bytes, 1);
    chk("add not branch", op_is_branch, 0);
    foreach (brs[k])
    begin
      opcode = (k % 3 == 0) ? OP_IDX_CMP_IMM : (k % 3 == 1) ? OP_IDX_LOAD_IMM : OP_SP_LOAD_IMM;
      @(negedge sys_clk);
      chk("long immediate", immediate_bytes, 2);
    end
    $display("test decode done");
    conclude();
  end
endmodule
`default_nettype wire
